// file: eaf_defs.vh
`ifndef EAF_DEFS_VH
`define EAF_DEFS_VH

// ********************************************************************
// Character/attribute FIFO geometry.
// ********************************************************************
`define EAF_FIFO_DEPTH 4
`define EAF_FIFO_AW 2
`define EAF_DATA_W 16
`define EAF_ADDR_W 16

// ********************************************************************
// Timing in bit times of the dot clock.
// ********************************************************************
`define EAF_BIT_CLKS 2
`define EAF_CELL_BITS 8
`define EAF_DRAIN_BITS 2
`define EAF_RD_BITS 3
`define EAF_CNT_W 8

// ********************************************************************
// Read sequencer states.
// ********************************************************************
`define EAF_ST_IDLE 2'h0
`define EAF_ST_VRD 2'h1
`define EAF_ST_CRD 2'h2

// ********************************************************************
// Reset and idle values.
// ********************************************************************
`define EAF_PIN_IDLE 1'h1
`define EAF_ADDR_RST 16'h0000

`endif

// file: eaf_ext_fifo_model.sv
`timescale 1ns/1ps
// ****
// Outside four-entry attribute FIFO.
// ****
module eaf_ext_fifo_model (
	input wire sys_clk_i,
	input wire reset_n_i,
	input wire fill_pin_i,
	input wire drain_pin_i,
	input wire [15:0] ram_data_i,
	output logic [15:0] ext_attr_o
);
	logic [15:0] mem_q [0:3];
	logic [2:0] wr_q;
	logic [2:0] rd_q;
	logic [15:0] hold_q;
	// Data is caught while the strobe is low, as the bus is let go when it rises.
	always @(posedge sys_clk_i) begin
		if (!fill_pin_i)
			hold_q <= ram_data_i;
	end
	// Push on the rising fill strobe; reset empties it like the inner FIFO.
	always @(posedge fill_pin_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_q <= 3'h0;
		end else begin
			mem_q[wr_q[1:0]] <= hold_q;
			wr_q <= wr_q + 3'h1;
		end
	end
	// Pop one word per cell on the rising drain strobe; an empty pop holds.
	always @(posedge drain_pin_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_q <= 3'h0;
			ext_attr_o <= 16'h0000;
		end else if (rd_q != wr_q) begin
			ext_attr_o <= mem_q[rd_q[1:0]];
			rd_q <= rd_q + 3'h1;
		end
	end
endmodule

// file: eaf_fifo.v
`timescale 1ns/1ps
`include "eaf_defs.vh"

module eaf_fifo #(
	parameter W = `EAF_DATA_W,
	parameter DEPTH = `EAF_FIFO_DEPTH,
	parameter AW = `EAF_FIFO_AW
) (
	input wire sys_clk_i,
	input wire reset_n_i,
	input wire flush_i,
	input wire push_i,
	input wire [W-1:0] push_data_i,
	input wire pop_i,
	output wire [W-1:0] pop_data_o,
	output wire full_o,
	output wire empty_o
);

	reg [W-1:0] mem_q [0:DEPTH-1];
	reg [W-1:0] rdata_q;
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0] count_q;
	wire do_push;
	wire do_pop;

	// A push into a full FIFO or a pop from an empty one is dropped.
	assign full_o = (count_q == DEPTH);
	assign empty_o = (count_q == {(AW+1){1'b0}});
	assign do_push = push_i && !full_o && !flush_i;
	assign do_pop = pop_i && !empty_o && !flush_i;
	assign pop_data_o = rdata_q;

	// Storage has no reset; the pointers and the level count define what is valid.
	always @(posedge sys_clk_i) begin
		if (do_push) begin
			mem_q[wp_q] <= push_data_i;
		end
	end

	// Pointers, level and the registered read word.
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			rdata_q <= {W{1'b0}};
		end else if (flush_i) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			rdata_q <= {W{1'b0}};
		end else begin
			if (do_push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (do_pop) begin
				rp_q <= rp_q + 1'b1;
				rdata_q <= mem_q[rp_q];
			end
			if (do_push && !do_pop) begin
				count_q <= count_q + 1'b1;
			end else if (do_pop && !do_push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule

// file: eaf_props.sv
`timescale 1ns/1ps
// ****
// Strobe timing checks at the top ports.
// ****
module eaf_props (
	input wire sys_clk_i,
	input wire reset_n_i,
	input wire video_enable_i,
	input wire fill_strobe_sel_i,
	input wire drain_strobe_sel_i,
	input wire ram_rd_n_o,
	input wire fill_pin_o,
	input wire drain_pin_o,
	input wire cpu_rd_done_o,
	input wire cell_start_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// A low fill strobe is always a copy of a display read.
	fill_gate_a: assert property (fill_strobe_sel_i && !fill_pin_o |-> !ram_rd_n_o)
		else $error("fill strobe low without a read");
	fill_start_a: assert property ($past(fill_strobe_sel_i) && $fell(fill_pin_o)
		|-> $fell(ram_rd_n_o))
		else $error("fill strobe out of step with the read strobe");
	// A read without a fill strobe must be a processor read.
	cpu_no_fill_a: assert property (fill_strobe_sel_i && video_enable_i
		&& $past(video_enable_i) && $fell(ram_rd_n_o) && fill_pin_o |-> ##[1:12] cpu_rd_done_o)
		else $error("read without fill strobe was not a processor read");
	drain_width_a: assert property ($past(drain_strobe_sel_i) && $rose(drain_pin_o)
		|-> drain_pin_o [*2] ##[1:5] !drain_pin_o)
		else $error("drain pulse outside one to three bit times");
	drain_cell_a: assert property ($past(drain_strobe_sel_i) && cell_start_o |-> drain_pin_o)
		else $error("no drain pulse at a cell start");
	// Intensity must not reach the pin while it carries the drain strobe.
	intensity_attribute_out_off_a: assert property ($past(drain_strobe_sel_i) && $rose(drain_pin_o)
		|-> cell_start_o)
		else $error("drain pin rose outside a cell start");
	fill_idle_a: assert property ((!video_enable_i) [*2] |=> fill_pin_o)
		else $error("fill pin left idle while video off");
	video_off_a: assert property ((!video_enable_i) [*2] |=> !cell_start_o)
		else $error("cell started while video off");
	cover property ($rose(drain_pin_o));
	cover property (cpu_rd_done_o);
	cover property ($fell(fill_pin_o));
endmodule

bind eaf_video_fifo_clk eaf_props u_props (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
	.video_enable_i(video_enable_i), .fill_strobe_sel_i(fill_strobe_sel_i),
	.drain_strobe_sel_i(drain_strobe_sel_i), .ram_rd_n_o(ram_rd_n_o),
	.fill_pin_o(fill_pin_o), .drain_pin_o(drain_pin_o),
	.cpu_rd_done_o(cpu_rd_done_o), .cell_start_o(cell_start_o));

// file: eaf_video_fifo_clk.v
`timescale 1ns/1ps
`include "eaf_defs.vh"

// Operation
// - A fill strobe clocks extra attribute data into the outside FIFO with every internal FIFO load.
// - The fill strobe copies the display RAM read strobe but only for video loads, never CPU reads.
// - The drain strobe pulses for one to three bit times whenever a new character cell starts.
// - While the shared pin carries the drain strobe the intensity attribute is disabled.
// - The dot clock or fill strobe pin stays high in reset and until video is enabled.
// - Reset empties the video FIFO and holds video off until the enable bit is set.
module eaf_video_fifo_clk #(
	parameter BIT_CLKS = `EAF_BIT_CLKS,
	parameter CELL_BITS = `EAF_CELL_BITS,
	parameter DRAIN_BITS = `EAF_DRAIN_BITS,
	parameter RD_BITS = `EAF_RD_BITS,
	parameter DATA_W = `EAF_DATA_W,
	parameter ADDR_W = `EAF_ADDR_W
) (
	input wire sys_clk_i,
	input wire reset_n_i,
	input wire video_enable_i,
	input wire fill_strobe_sel_i,
	input wire drain_strobe_sel_i,
	input wire intensity_attr_i,
	input wire cpu_rd_req_i,
	input wire [ADDR_W-1:0] cpu_rd_addr_i,
	input wire [DATA_W-1:0] ram_data_i,
	output wire ram_rd_n_o,
	output wire [ADDR_W-1:0] ram_addr_o,
	output wire fill_pin_o,
	output wire drain_pin_o,
	output wire cpu_rd_done_o,
	output wire [DATA_W-1:0] cpu_rd_data_o,
	output wire [DATA_W-1:0] char_attr_o,
	output wire cell_start_o
);

	localparam [`EAF_CNT_W-1:0] BIT_LAST = BIT_CLKS[`EAF_CNT_W-1:0] - 1'b1;
	localparam [`EAF_CNT_W-1:0] BIT_HALF = BIT_CLKS[`EAF_CNT_W:1];
	localparam [`EAF_CNT_W-1:0] CELL_LAST = CELL_BITS[`EAF_CNT_W-1:0] - 1'b1;
	localparam [`EAF_CNT_W-1:0] DRAIN_LEN = DRAIN_BITS[`EAF_CNT_W-1:0];
	localparam [`EAF_CNT_W-1:0] RD_LEN = RD_BITS[`EAF_CNT_W-1:0];

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	reg vid_on_q;
	reg [`EAF_CNT_W-1:0] div_q;
	reg [`EAF_CNT_W-1:0] cell_q;
	reg [`EAF_CNT_W-1:0] drain_cnt_q;
	reg [`EAF_CNT_W-1:0] rd_cnt_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [ADDR_W-1:0] vid_addr_q;
	reg [ADDR_W-1:0] addr_q;
	reg [ADDR_W-1:0] addr_d;
	reg ram_rd_n_q;
	reg ram_rd_n_d;
	reg fill_pin_q;
	reg fill_pin_d;
	reg drain_pin_q;
	reg drain_pin_d;
	reg cpu_done_q;
	reg [DATA_W-1:0] cpu_data_q;
	reg cell_start_q;
	reg [DATA_W-1:0] data_s1_q;
	reg [DATA_W-1:0] data_s2_q;
	wire bit_tick;
	wire cell_start;
	wire rd_end;
	wire fifo_full;
	wire fifo_empty;
	wire fifo_push;

	// Saturating down-count step used by the drain and read strobe counters.
	function [`EAF_CNT_W-1:0] cnt_dec;
		input [`EAF_CNT_W-1:0] v;
		begin
			cnt_dec = (v == {`EAF_CNT_W{1'b0}}) ? v : v - 1'b1;
		end
	endfunction

	// ****************************************************************
	// Bit time base and character cell timing.
	// ****************************************************************
	assign bit_tick = (div_q == BIT_LAST);
	assign cell_start = vid_on_q && bit_tick && (cell_q == {`EAF_CNT_W{1'b0}});
	assign rd_end = bit_tick && (rd_cnt_q == {{(`EAF_CNT_W-1){1'b0}}, 1'b1});

	// The enable comes from the control register on this clock, so no synchroniser.
	// Dropping it flushes the FIFO and rewinds the cell timing, as after reset.
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			vid_on_q <= 1'b0;
			div_q <= {`EAF_CNT_W{1'b0}};
			cell_q <= {`EAF_CNT_W{1'b0}};
			drain_cnt_q <= {`EAF_CNT_W{1'b0}};
			cell_start_q <= 1'b0;
		end else begin
			vid_on_q <= video_enable_i;
			div_q <= bit_tick ? {`EAF_CNT_W{1'b0}} : div_q + 1'b1;
			cell_start_q <= cell_start;
			if (!vid_on_q) begin
				cell_q <= {`EAF_CNT_W{1'b0}};
				drain_cnt_q <= {`EAF_CNT_W{1'b0}};
			end else begin
				if (bit_tick) begin
					cell_q <= (cell_q == CELL_LAST) ? {`EAF_CNT_W{1'b0}} : cell_q + 1'b1;
				end
				if (cell_start) begin
					drain_cnt_q <= DRAIN_LEN;
				end else if (bit_tick) begin
					drain_cnt_q <= cnt_dec(drain_cnt_q);
				end
			end
		end
	end

	// ****************************************************************
	// Display RAM read sequencer.
	// ****************************************************************
	// Video loads win over CPU reads so the display never starves; a CPU read
	// waits as long as video is on and the FIFO has room for another word.
	always @* begin
		state_d = state_q;
		addr_d = addr_q;
		case (state_q)
		`EAF_ST_IDLE: begin
			if (bit_tick && vid_on_q && !fifo_full) begin
				state_d = `EAF_ST_VRD;
				addr_d = vid_addr_q;
			end else if (bit_tick && cpu_rd_req_i && !cpu_done_q) begin
				state_d = `EAF_ST_CRD;
				addr_d = cpu_rd_addr_i;
			end
		end
		`EAF_ST_VRD, `EAF_ST_CRD: begin
			if (rd_end) begin
				state_d = `EAF_ST_IDLE;
			end
		end
		default: begin
			state_d = `EAF_ST_IDLE;
		end
		endcase
	end

	// Strobe and pin values for the next cycle; both pins come from flops.
	always @* begin
		ram_rd_n_d = (state_d == `EAF_ST_IDLE);
		if (!vid_on_q) begin
			fill_pin_d = `EAF_PIN_IDLE;
		end else if (fill_strobe_sel_i) begin
			fill_pin_d = !(state_d == `EAF_ST_VRD);
		end else begin
			// The pin is a flop, so it takes the level of the coming cycle, high first half.
			fill_pin_d = bit_tick || ((div_q + 1'b1) < BIT_HALF);
		end
		if (drain_strobe_sel_i) begin
			drain_pin_d = (drain_cnt_q != {`EAF_CNT_W{1'b0}}) || cell_start;
		end else begin
			drain_pin_d = vid_on_q && intensity_attr_i;
		end
	end

	// Sequencer registers and the video address walk.
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= `EAF_ST_IDLE;
			addr_q <= `EAF_ADDR_RST;
			vid_addr_q <= `EAF_ADDR_RST;
			rd_cnt_q <= {`EAF_CNT_W{1'b0}};
			ram_rd_n_q <= `EAF_PIN_IDLE;
			fill_pin_q <= `EAF_PIN_IDLE;
			drain_pin_q <= 1'b0;
			cpu_done_q <= 1'b0;
			cpu_data_q <= {DATA_W{1'b0}};
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			ram_rd_n_q <= ram_rd_n_d;
			fill_pin_q <= fill_pin_d;
			drain_pin_q <= drain_pin_d;
			cpu_done_q <= (state_q == `EAF_ST_CRD) && rd_end;
			if (state_q == `EAF_ST_IDLE && state_d != `EAF_ST_IDLE) begin
				rd_cnt_q <= RD_LEN;
			end else if (bit_tick) begin
				rd_cnt_q <= cnt_dec(rd_cnt_q);
			end
			if (!vid_on_q) begin
				vid_addr_q <= `EAF_ADDR_RST;
			end else if (fifo_push) begin
				vid_addr_q <= vid_addr_q + 1'b1;
			end
			if ((state_q == `EAF_ST_CRD) && rd_end) begin
				cpu_data_q <= data_s2_q;
			end
		end
	end

	// ****************************************************************
	// Data capture and the internal character/attribute FIFO.
	// ****************************************************************
	// The bus comes from a pin, so it passes two flops before use. Words are taken
	// at the last cycle of the strobe; the read must last at least three clocks.
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			data_s1_q <= {DATA_W{1'b0}};
			data_s2_q <= {DATA_W{1'b0}};
		end else begin
			data_s1_q <= ram_data_i;
			data_s2_q <= data_s1_q;
		end
	end

	assign fifo_push = (state_q == `EAF_ST_VRD) && rd_end && vid_on_q;

	// Four levels deep so an outside copy driven by the two strobes stays aligned.
	eaf_fifo #(
		.W(DATA_W),
		.DEPTH(`EAF_FIFO_DEPTH),
		.AW(`EAF_FIFO_AW)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.flush_i(!vid_on_q),
		.push_i(fifo_push),
		.push_data_i(data_s2_q),
		.pop_i(cell_start),
		.pop_data_o(char_attr_o),
		.full_o(fifo_full),
		.empty_o(fifo_empty)
	);

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign ram_rd_n_o = ram_rd_n_q;
	assign ram_addr_o = addr_q;
	assign fill_pin_o = fill_pin_q;
	assign drain_pin_o = drain_pin_q;
	assign cpu_rd_done_o = cpu_done_q;
	assign cpu_rd_data_o = cpu_data_q;
	assign cell_start_o = cell_start_q;

endmodule

// file: eaf_video_fifo_clk_tb_top.sv
`timescale 1ns/1ps
`include "eaf_defs.vh"
// ****
// Bench for the attribute FIFO strobes.
// ****
module eaf_video_fifo_clk_tb_top;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic vid_en = 1'h0;
	logic drain_sel = 1'h1;
	logic fill_sel = 1'h1;
	logic intensity_attribute_out = 1'h0;
	logic cpu_req = 1'h0;
	logic [15:0] cpu_addr = 16'h0000;
	logic [15:0] ram_data;
	logic ram_rd_n, fill, drain, cpu_done, cell_start;
	logic [15:0] ram_addr, cpu_data, char_attr, ext_attr;
	logic [15:0] prev_attr = 16'h0000;
	logic watch = 1'h0;
	int word_idx = 0;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	// The RAM shows the inverse word once released, so stale data never matches.
	always #4 clk = ~clk;
	assign ram_data = ram_rd_n ? ~(ram_addr ^ 16'h5a5a) : ram_addr ^ 16'h5a5a;
	eaf_video_fifo_clk dut (.sys_clk_i(clk), .reset_n_i(rst_n), .video_enable_i(vid_en),
		.fill_strobe_sel_i(fill_sel), .drain_strobe_sel_i(drain_sel), .intensity_attr_i(intensity_attribute_out),
		.cpu_rd_req_i(cpu_req), .cpu_rd_addr_i(cpu_addr), .ram_data_i(ram_data),
		.ram_rd_n_o(ram_rd_n), .ram_addr_o(ram_addr), .fill_pin_o(fill), .drain_pin_o(drain),
		.cpu_rd_done_o(cpu_done), .cpu_rd_data_o(cpu_data), .char_attr_o(char_attr),
		.cell_start_o(cell_start));
	eaf_ext_fifo_model far (.sys_clk_i(clk), .reset_n_i(rst_n), .fill_pin_i(fill),
		.drain_pin_i(drain), .ram_data_i(ram_data), .ext_attr_o(ext_attr));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Every new cell word must be the next video word, inside and outside alike.
	always @(posedge clk) begin
		#1;
		if (watch && cell_start === 1'h1 && char_attr !== prev_attr) begin
			chk("cell word", 16'(word_idx) ^ 16'h5a5a, char_attr);
			chk("outside word", 16'(word_idx) ^ 16'h5a5a, ext_attr);
			word_idx++;
			prev_attr = char_attr;
		end
	end
	// A hang counts as a mismatch and closes the run.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic t_reset();
		rst_n = 1'h0;
		watch = 1'h0;
		tick(5);
		chk("read strobe", 1'h1, ram_rd_n);
		chk("fill pin", 1'h1, fill);
		chk("drain pin", 1'h0, drain);
		rst_n = 1'h1;
		word_idx = 0;
		prev_attr = 16'h0000;
		$display("test reset done");
	endtask
	task automatic t_stream(input int n);
		int goal;
		int c;
		goal = word_idx + n;
		vid_en = 1'h1;
		watch = 1'h1;
		for (c = 0; c < 1000 && word_idx < goal; c++)
			tick(1);
		chk("cell count", 16'(goal), 16'(word_idx));
		$display("test stream done");
	endtask
	task automatic t_cpu();
		int c;
		cpu_addr = 16'h1234;
		cpu_req = 1'h1;
		for (c = 0; c < 400 && cpu_done !== 1'h1; c++)
			tick(1);
		cpu_req = 1'h0;
		chk("cpu word", 16'h1234 ^ 16'h5a5a, cpu_data);
		$display("test cpu read done");
	endtask
	task automatic t_intensity_attribute_out();
		int c;
		watch = 1'h0;
		drain_sel = 1'h0;
		intensity_attribute_out = 1'h1;
		tick(3);
		chk("intensity pin", 1'h1, drain);
		intensity_attribute_out = 1'h0;
		tick(3);
		chk("intensity pin", 1'h0, drain);
		drain_sel = 1'h1;
		intensity_attribute_out = 1'h1;
		// Look between pulses, so only a leaking intensity could hold the pin high.
		for (c = 0; c < 40 && cell_start !== 1'h1; c++)
			tick(1);
		chk("drain strobe", 1'h1, drain);
		tick(8);
		chk("shared pin idle", 1'h0, drain);
		intensity_attribute_out = 1'h0;
		$display("test intensity done");
	endtask
	// The dot clock mode runs last, as its edges would upset the outside FIFO.
	task automatic t_stop();
		int highs;
		watch = 1'h0;
		fill_sel = 1'h0;
		tick(2);
		highs = 0;
		repeat (16) begin
			tick(1);
			if (fill === 1'h1)
				highs++;
		end
		chk("dot clock highs", 16'(16 / `EAF_BIT_CLKS * (`EAF_BIT_CLKS / 2)), 16'(highs));
		vid_en = 1'h0;
		tick(3);
		repeat (20) begin
			tick(1);
			chk("fill pin", 1'h1, fill);
		end
		fill_sel = 1'h1;
		tick(2);
		chk("fill pin", 1'h1, fill);
		$display("test stop done");
	endtask
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// The second reset mid-run must bring both FIFOs back in step.
	initial begin
		t_reset();
		t_stream(6);
		t_cpu();
		t_stream(4);
		t_reset();
		t_stream(5);
		t_intensity_attribute_out();
		t_stop();
		final_report();
	end
endmodule
